// >>> pkt_cmd_pkg.sv
// Constants shared by the packet command core and its helpers.
package pkt_cmd_pkg;
  localparam logic [1:0] CLASS_CMD    = 2'h0;
  localparam logic [1:0] CLASS_RESP   = 2'h1;
  localparam logic [1:0] CLASS_REPORT = 2'h2;
  localparam logic [1:0] CLASS_ERR    = 2'h3;
  localparam int         CODE_W       = 6;
  localparam logic [5:0] CODE_ECHO    = 6'h00;
  localparam logic [5:0] CODE_VERSION = 6'h01;
  localparam logic [5:0] CODE_UWRITE  = 6'h02;
  localparam logic [5:0] CODE_UREAD   = 6'h03;
  localparam logic [5:0] CODE_SAVE    = 6'h04;
  localparam logic [5:0] CODE_RESTART = 6'h05;
  localparam logic [5:0] CODE_CLEAR   = 6'h06;
  localparam logic [4:0] ECHO_MAX     = 5'h10;
  localparam logic [4:0] USER_LEN     = 5'h10;
  localparam logic [4:0] VER_LEN      = 5'h10;
  localparam logic [4:0] CODE5_LEN    = 5'h03;
  localparam logic [4:0] MAX_LEN      = 5'h16;
  localparam int         USER_BYTES   = 16;
  localparam logic [7:0] REBOOT_B0    = 8'h08;
  localparam logic [7:0] REBOOT_B1    = 8'h12;
  localparam logic [7:0] REBOOT_B2    = 8'h63;
  localparam logic [7:0] HRST_B0      = 8'h0C;
  localparam logic [7:0] HRST_B1      = 8'h1C;
  localparam logic [7:0] HRST_B2      = 8'h61;
  localparam logic [7:0] HOFF_B0      = 8'h03;
  localparam logic [7:0] HOFF_B1      = 8'h0B;
  localparam logic [7:0] HOFF_B2      = 8'h5F;
  localparam logic [7:0] BLANK_CHAR   = 8'h20;
  localparam int         CLK_HZ       = 125000000;
  localparam int         HRST_MS      = 1500;
  localparam int         BOOT_MS      = 3000;
  localparam int         HRST_CYC     = (CLK_HZ / 1000) * HRST_MS;
  localparam int         BOOT_CYC     = (CLK_HZ / 1000) * BOOT_MS;
  localparam int         PWR_PULSE_W  = 32;
endpackage : pkt_cmd_pkg

// >>> pkt_cmd_skid.sv
// Two-entry valid/ready buffer for the response byte stream.
`timescale 1ns/1ns
`default_nettype none
module pkt_cmd_skid #(
  parameter int W = 9
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] mem_reg [2];
  logic         rd_reg;
  logic         wr_reg;
  logic [1:0]   cnt_reg;
  wire          push = in_valid_i && (cnt_reg != 2'h2);
  wire          pop  = out_ready_i && (cnt_reg != 2'h0);

  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_reg];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem_reg[wr_reg] <= in_data_i;
  end
endmodule : pkt_cmd_skid
`default_nettype wire

// >>> pkt_cmd_timer.sv
// Down counter that holds a level for a loaded number of cycles.
`timescale 1ns/1ns
`default_nettype none
module pkt_cmd_timer #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              busy_o,
  output logic              done_o
);
  logic [W-1:0] cnt_reg;

  assign busy_o = (cnt_reg != '0);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
      if (load_i) cnt_reg <= count_i;
      else if (busy_o) cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule : pkt_cmd_timer
`default_nettype wire

// >>> pkt_cmd_core.sv
// Command interpreter for host packets 0 to 6 with response packet builder.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Every accepted command yields exactly one response or error packet.
// - Response type carries the command's low six code bits.
// - Echo accepts zero to sixteen payload bytes of any value.
// - Echo answers type 0x40 with identical length and payload.
// - Version query answers 0x41 with a sixteen-byte ASCII string.
// - User write takes sixteen bytes, stores them, answers 0x42 empty.
// - User read answers 0x43 with the sixteen stored bytes.
// - At power-up the configuration is loaded from nonvolatile storage.
// - Save-state persists current settings and answers 0x44.
// - Reporting, fail-safe and watchdog are never saved as boot state.
// - Code 5 with 8,18,99 requests a simulated power-on restart.
// - Acknowledge first, then restart; commands ignored up to three seconds.
// - Code 5 with 12,28,97 pulses the host reset output.
// - Host held in reset about 1.5 s, then self reboot.
// - Code 5 with 3,11,95 pulses host power for configured length.
// - After power cycling the host the device reboots itself.
// - Each valid code-5 request answers type 0x45, empty payload.
// - Clear fills character memory with 0x20, cursor home, answers 0x46.
// - Type byte top bits give class, low six bits the code.
// - Packet is type, length 0 to 22, then payload; no CRC byte follows.
// - Every packet is answered within 250 ms.
module pkt_cmd_core
  import pkt_cmd_pkg::*;
#(
  parameter int         HRST_CYCLES = HRST_CYC,
  parameter int         BOOT_CYCLES = BOOT_CYC,
  parameter logic [7:0] VER_BYTE0   = 8'h4D  // Arbitrary identity byte.
) (
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   ARST_N_I,
  input  wire logic                   CMD_VALID_I,
  input  wire logic [7:0]             CMD_TYPE_I,
  input  wire logic [4:0]             CMD_LEN_I,
  input  wire logic [8*22-1:0]        CMD_DATA_I,
  output logic                        CMD_READY_O,
  output logic [8:0]                  RSP_BYTE_O,
  output logic                        RSP_VALID_O,
  input  wire logic                   RSP_READY_I,
  input  wire logic [8*USER_BYTES-1:0] NV_USER_I,
  output logic [8*USER_BYTES-1:0]     NV_USER_O,
  output logic                        NV_USER_WE_O,
  output logic                        SAVE_STATE_O,
  output logic                        BOOT_LOAD_O,
  output logic                        CLEAR_SCREEN_O,
  output logic                        HOST_RESET_O,
  output logic                        HOST_POWER_O,
  input  wire logic [PWR_PULSE_W-1:0] PWR_PULSE_CYC_I,
  output logic                        BOOTING_O
);
  typedef enum {ST_BOOT, ST_IDLE, ST_SEND, ST_HRST, ST_HPWR, ST_REBOOT} state_e;
  typedef enum {ACT_NONE, ACT_REBOOT, ACT_HRST, ACT_HPWR} act_e;

  state_e           state_reg;
  act_e             act_reg;
  logic [7:0]       type_reg;
  logic [4:0]       len_reg;
  logic [4:0]       idx_reg;
  logic [8*22-1:0]  pay_reg;
  logic [8*USER_BYTES-1:0] user_reg;
  logic             hdr_reg;
  logic             lenb_reg;
  logic [8:0]       sk_data;
  logic             sk_valid;
  logic             sk_ready;
  logic             tmr_load;
  logic [31:0]      tmr_count;
  logic             tmr_busy;
  logic             tmr_done;
  logic [7:0]       ver_str [16];

  // Version string: model letters and revisions.
  assign ver_str = '{VER_BYTE0, 8'h44, 8'h4C, 8'h31, 8'h30, 8'h30, 8'h3A, 8'h68,
                     8'h31, 8'h2E, 8'h30, 8'h2C, 8'h73, 8'h31, 8'h2E, 8'h30};

  // ****************************************************************
  // Command validation
  // ****************************************************************
  wire [5:0] code   = CMD_TYPE_I[5:0];
  wire [7:0] b0     = CMD_DATA_I[7:0];
  wire [7:0] b1     = CMD_DATA_I[15:8];
  wire [7:0] b2     = CMD_DATA_I[23:16];
  wire       is_cmd = (CMD_TYPE_I[7:6] == CLASS_CMD);
  wire       m_rb   = (b0 == REBOOT_B0) && (b1 == REBOOT_B1) && (b2 == REBOOT_B2);
  wire       m_hr   = (b0 == HRST_B0) && (b1 == HRST_B1) && (b2 == HRST_B2);
  wire       m_hp   = (b0 == HOFF_B0) && (b1 == HOFF_B1) && (b2 == HOFF_B2);
  wire       len_ok =
    (code == CODE_ECHO)    ? (CMD_LEN_I <= ECHO_MAX) :
    (code == CODE_UWRITE)  ? (CMD_LEN_I == USER_LEN) :
    (code == CODE_RESTART) ? (CMD_LEN_I == CODE5_LEN) && (m_rb || m_hr || m_hp) :
    (code <= CODE_CLEAR)   ? (CMD_LEN_I == 5'h00) : 1'b0;
  wire       good   = is_cmd && len_ok && (CMD_LEN_I <= MAX_LEN);
  wire       take   = CMD_VALID_I && CMD_READY_O;
  wire       g_ver  = (code == CODE_VERSION);
  wire       g_ur   = (code == CODE_UREAD);
  wire       g_echo = (code == CODE_ECHO);
  wire [4:0] rsp_len = !good  ? 5'h00 :
                       g_echo ? CMD_LEN_I :
                       g_ver  ? VER_LEN :
                       g_ur   ? USER_LEN : 5'h00;

  // ****************************************************************
  // Response byte selection
  // ****************************************************************
  // The byte counter runs from one, so payload byte k goes out while it holds k plus one.
  wire [5:0] tcode = type_reg[5:0];
  wire [4:0] pidx  = idx_reg - 5'h01;
  wire [7:0] pay_byte = (tcode == CODE_VERSION && type_reg[7:6] == CLASS_RESP) ? ver_str[pidx[3:0]] :
                        (tcode == CODE_UREAD && type_reg[7:6] == CLASS_RESP) ? user_reg[pidx[3:0]*8 +: 8] :
                        pay_reg[pidx*8 +: 8];
  wire       last_byte = !hdr_reg && lenb_reg && (idx_reg == len_reg);
  wire [7:0] out_byte  = hdr_reg ? type_reg : !lenb_reg ? {3'h0, len_reg} : pay_byte;
  assign sk_data  = {last_byte || (!hdr_reg && !lenb_reg && len_reg == 5'h00), out_byte};
  assign sk_valid = (state_reg == ST_SEND);
  wire       sent = sk_valid && sk_ready && sk_data[8];

  pkt_cmd_skid #(.W(9)) u_skid (
    .clk_i       (CORE_CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_data_i   (sk_data),
    .in_valid_i  (sk_valid),
    .in_ready_o  (sk_ready),
    .out_data_o  (RSP_BYTE_O),
    .out_valid_o (RSP_VALID_O),
    .out_ready_i (RSP_READY_I)
  );

  assign tmr_load  = (sent && act_reg != ACT_NONE) || (tmr_done && (state_reg == ST_HRST || state_reg == ST_HPWR))
                     || (state_reg == ST_BOOT && !tmr_busy && !tmr_done && !BOOTING_O);
  assign tmr_count = (sent && act_reg == ACT_HRST) ? HRST_CYCLES[31:0] :
                     (sent && act_reg == ACT_HPWR) ? PWR_PULSE_CYC_I :
                     BOOT_CYCLES[31:0];

  pkt_cmd_timer #(.W(32)) u_timer (
    .clk_i    (CORE_CLK_I),
    .arst_n_i (ARST_N_I),
    .load_i   (tmr_load),
    .count_i  (tmr_count),
    .busy_o   (tmr_busy),
    .done_o   (tmr_done)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= ST_BOOT;
      act_reg   <= ACT_NONE;
      type_reg  <= 8'h00;
      len_reg   <= 5'h00;
      idx_reg   <= 5'h00;
      pay_reg   <= '0;
      hdr_reg   <= 1'b1;
      lenb_reg  <= 1'b0;
      BOOTING_O <= 1'b0;
    end else begin
      case (state_reg)
        ST_BOOT: begin
          BOOTING_O <= 1'b1;
          if (tmr_done) begin
            BOOTING_O <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (take) begin
            type_reg  <= {good ? CLASS_RESP : CLASS_ERR, code};
            len_reg   <= rsp_len;
            pay_reg   <= CMD_DATA_I;
            idx_reg   <= 5'h01;
            hdr_reg   <= 1'b1;
            lenb_reg  <= 1'b0;
            act_reg   <= !(good && code == CODE_RESTART) ? ACT_NONE :
                         m_rb ? ACT_REBOOT : m_hr ? ACT_HRST : ACT_HPWR;
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (sk_ready) begin
            if (hdr_reg) hdr_reg <= 1'b0;
            else if (!lenb_reg) lenb_reg <= 1'b1;
            else idx_reg <= idx_reg + 5'h01;
            if (sk_data[8]) begin
              case (act_reg)  // acknowledge goes out before any restart.
                ACT_REBOOT: state_reg <= ST_BOOT;
                ACT_HRST:   state_reg <= ST_HRST;
                ACT_HPWR:   state_reg <= ST_HPWR;
                default:    state_reg <= ST_IDLE;
              endcase
              BOOTING_O <= (act_reg != ACT_NONE);
            end
          end
        end
        ST_HRST, ST_HPWR: begin
          if (tmr_done) state_reg <= ST_BOOT;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Side effects and persistent user area
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      user_reg       <= '0;
      NV_USER_O      <= '0;
      NV_USER_WE_O   <= 1'b0;
      SAVE_STATE_O   <= 1'b0;
      BOOT_LOAD_O    <= 1'b0;
      CLEAR_SCREEN_O <= 1'b0;
      HOST_RESET_O   <= 1'b0;
      HOST_POWER_O   <= 1'b0;
      CMD_READY_O    <= 1'b0;
    end else begin
      CMD_READY_O    <= (state_reg == ST_IDLE) && !take;
      BOOT_LOAD_O    <= (state_reg == ST_BOOT) && tmr_done;
      if (BOOT_LOAD_O) user_reg <= NV_USER_I;
      NV_USER_WE_O   <= take && good && (code == CODE_UWRITE);
      SAVE_STATE_O   <= take && good && (code == CODE_SAVE);
      CLEAR_SCREEN_O <= take && good && (code == CODE_CLEAR);
      if (take && good && code == CODE_UWRITE) begin
        user_reg  <= CMD_DATA_I[8*USER_BYTES-1:0];
        NV_USER_O <= CMD_DATA_I[8*USER_BYTES-1:0];
      end
      HOST_RESET_O <= (state_reg == ST_HRST) && !tmr_done;
      HOST_POWER_O <= (state_reg == ST_HPWR) && !tmr_done;
    end
  end
endmodule : pkt_cmd_core
`default_nettype wire

// >>> pkt_cmd_chk.sv
// Concurrent checks on the packet command core ports.
`timescale 1ns/1ns
`default_nettype none
module pkt_cmd_chk
  import pkt_cmd_pkg::*;
#(
  parameter int HRST_CYCLES = 20
) (
  input wire logic       CORE_CLK_I,
  input wire logic       ARST_N_I,
  input wire logic       CMD_VALID_I,
  input wire logic [7:0] CMD_TYPE_I,
  input wire logic       CMD_READY_O,
  input wire logic [8:0] RSP_BYTE_O,
  input wire logic       RSP_VALID_O,
  input wire logic       RSP_READY_I,
  input wire logic       NV_USER_WE_O,
  input wire logic       SAVE_STATE_O,
  input wire logic       CLEAR_SCREEN_O,
  input wire logic       HOST_RESET_O,
  input wire logic       HOST_POWER_O,
  input wire logic       BOOTING_O
);
  logic        take;
  logic        hs;
  logic [5:0]  cq0_reg;
  logic [5:0]  cq1_reg;
  logic [1:0]  open_reg;
  logic        first_reg;
  logic [31:0] hcnt_reg;
  assign take = CMD_VALID_I && CMD_READY_O;
  assign hs   = RSP_VALID_O && RSP_READY_I;
  // Two codes are kept because a stalled packet may still wait when the next is taken.
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cq0_reg   <= 6'h00;
      cq1_reg   <= 6'h00;
      open_reg  <= 2'h0;
      first_reg <= 1'b1;
      hcnt_reg  <= 32'h0;
    end else begin
      if (take) cq0_reg <= CMD_TYPE_I[5:0];
      if (take) cq1_reg <= cq0_reg;
      open_reg  <= open_reg + {1'b0, take} - {1'b0, hs && RSP_BYTE_O[8]};
      if (hs) first_reg <= RSP_BYTE_O[8];
      hcnt_reg  <= HOST_RESET_O ? hcnt_reg + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  a_code_copy: assert property (hs && first_reg |-> RSP_BYTE_O[6] &&
    RSP_BYTE_O[5:0] == (open_reg == 2'h2 ? cq1_reg : cq0_reg)) else $error("response code differs");
  a_rsp_hold: assert property (RSP_VALID_O && !RSP_READY_I |=> RSP_VALID_O && $stable(RSP_BYTE_O))
    else $error("stalled byte lost");
  a_ready_drop: assert property (take |=> !CMD_READY_O) else $error("second command taken");
  a_rsp_soon: assert property (take |-> ##[2:4] RSP_VALID_O) else $error("no response");
  a_boot_quiet: assert property (BOOTING_O |-> !CMD_READY_O) else $error("ready while booting");
  a_pin_quiet: assert property (HOST_RESET_O || HOST_POWER_O |-> !CMD_READY_O)
    else $error("ready during host pulse");
  a_hrst_len: assert property ($fell(HOST_RESET_O) |-> hcnt_reg == 32'(HRST_CYCLES))
    else $error("host reset length wrong");
  a_we_pulse: assert property (NV_USER_WE_O |=> !NV_USER_WE_O) else $error("write strobe stuck");
  a_clr_pulse: assert property (CLEAR_SCREEN_O |=> !CLEAR_SCREEN_O) else $error("clear stuck");
  a_save_pulse: assert property (SAVE_STATE_O |=> !SAVE_STATE_O) else $error("save stuck");
  c_echo: cover property (take && CMD_TYPE_I == 8'h00);
  c_hrst: cover property ($rose(HOST_RESET_O));
  c_stall: cover property (RSP_VALID_O && !RSP_READY_I);
endmodule : pkt_cmd_chk
bind pkt_cmd_core pkt_cmd_chk #(.HRST_CYCLES(HRST_CYCLES)) pkt_cmd_chk_inst (.CORE_CLK_I, .ARST_N_I,
  .CMD_VALID_I, .CMD_TYPE_I, .CMD_READY_O, .RSP_BYTE_O, .RSP_VALID_O, .RSP_READY_I, .NV_USER_WE_O,
  .SAVE_STATE_O, .CLEAR_SCREEN_O, .HOST_RESET_O, .HOST_POWER_O, .BOOTING_O);
`default_nettype wire

// >>> host_side.sv
// Host side model: response sink with stalls and the user nonvolatile store.
`timescale 1ns/1ns
`default_nettype none
module host_side
  import pkt_cmd_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    slow_i,
  input  wire logic [8:0]              rsp_byte_i,
  input  wire logic                    rsp_valid_i,
  output logic                         rsp_ready_o,
  input  wire logic [8*USER_BYTES-1:0] nv_data_i,
  input  wire logic                    nv_we_i,
  output logic [8*USER_BYTES-1:0]      nv_data_o
);
  logic [8:0] q[$];
  // A slow host takes a byte on every other cycle only.
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_ready_o <= 1'b0;
    end else begin
      rsp_ready_o <= slow_i ? !rsp_ready_o : 1'b1;
      if (rsp_valid_i && rsp_ready_o) q.push_back(rsp_byte_i);
    end
  end
  // The store keeps its contents through resets, as flash does.
  initial nv_data_o = {USER_BYTES{8'hA5}};
  always @(posedge clk_i) begin
    if (nv_we_i) nv_data_o <= nv_data_i;
  end
endmodule : host_side
`default_nettype wire

// >>> pkt_cmd_core_bench.sv
// Self-checking bench for the packet command core.
`timescale 1ns/1ns
`default_nettype none
module pkt_cmd_core_bench
  import pkt_cmd_pkg::*;
;
  logic         clk, arst_n, cmd_valid, slow, rdy, rsp_valid, rsp_ready;
  logic         nv_we, save, bload, clr, hrst, hpwr, booting;
  logic [7:0]   cmd_type;
  logic [4:0]   cmd_len;
  logic [175:0] cmd_data;
  logic [8:0]   rsp_byte;
  logic [127:0] nv_in, nv_out;
  logic [31:0]  pw_len;
  int           bad_count = 0, check_count = 0;
  int           n_we = 0, n_save = 0, n_load = 0, n_clr = 0, n_hr = 0, n_pw = 0;
  logic [175:0] r5 [3] = '{176'h631208, 176'h611C0C, 176'h5F0B03};
  localparam logic [175:0] PAT = 176'h0123456789ABCDEFFEDCBA9876543210;
  localparam logic [175:0] UD  = 176'hC3A55A3C0F1E2D4B69788796B4D2E1F0;
  initial clk = 1'b0;
  always #4 clk = ~clk;
  pkt_cmd_core #(.HRST_CYCLES(20), .BOOT_CYCLES(30)) pkt_cmd_core_inst (.CORE_CLK_I(clk), .ARST_N_I(arst_n),
    .CMD_VALID_I(cmd_valid), .CMD_TYPE_I(cmd_type), .CMD_LEN_I(cmd_len), .CMD_DATA_I(cmd_data),
    .CMD_READY_O(rdy), .RSP_BYTE_O(rsp_byte), .RSP_VALID_O(rsp_valid), .RSP_READY_I(rsp_ready),
    .NV_USER_I(nv_in), .NV_USER_O(nv_out), .NV_USER_WE_O(nv_we), .SAVE_STATE_O(save), .BOOT_LOAD_O(bload),
    .CLEAR_SCREEN_O(clr), .HOST_RESET_O(hrst), .HOST_POWER_O(hpwr), .PWR_PULSE_CYC_I(pw_len),
    .BOOTING_O(booting));
  host_side host_side_inst (.clk_i(clk), .arst_n_i(arst_n), .slow_i(slow), .rsp_byte_i(rsp_byte),
    .rsp_valid_i(rsp_valid), .rsp_ready_o(rsp_ready), .nv_data_i(nv_out), .nv_we_i(nv_we), .nv_data_o(nv_in));
  always @(posedge clk) begin
    n_we <= n_we + int'(nv_we);
    n_save <= n_save + int'(save);
    n_load <= n_load + int'(bload);
    n_clr <= n_clr + int'(clr);
    n_hr <= n_hr + int'(hrst);
    n_pw <= n_pw + int'(hpwr);
  end
  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [175:0] seen, input logic [175:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (rdy === 1'b1) break;
    end
    if (i == 3000) begin
      bad_count++;
      close_out();
    end
  endtask : wait_rdy
  // The command stands until the edge where ready is seen high.
  task automatic send(input logic [7:0] t, input logic [4:0] n, input logic [175:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_type <= t;
    cmd_len <= n;
    cmd_data <= d;
    wait_rdy();
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : send
  task automatic recv(input string nm, input logic [7:0] t, input logic [4:0] n, input logic [175:0] d);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clk);
      if (host_side_inst.q.size() > 0 && host_side_inst.q[$][8]) break;
    end
    if (i == 400) begin
      bad_count++;
      close_out();
    end
    chk({nm, " type"}, host_side_inst.q[0][7:0], t);
    chk({nm, " len"}, host_side_inst.q[1][7:0], n);
    chk({nm, " size"}, host_side_inst.q.size(), 32'(n) + 32'h2);
    for (i = 0; i < 32'(n) && d != '0; i++) chk({nm, " data"}, host_side_inst.q[2+i][7:0], d[8*i+:8]);
    host_side_inst.q.delete();
    $display("Test %s done", nm);
  endtask : recv
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_type = 8'h00;
    cmd_len = 5'h00;
    cmd_data = '0;
    slow = 1'b0;
    pw_len = 32'hA;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("boot", {rdy, booting}, 2'h1);
    wait_rdy();
    chk("boot loads", n_load, 1);
    send(8'h00, 5'h00, '0);
    recv("echo empty", 8'h40, 5'h00, '0);
    slow <= 1'b1;
    send(8'h00, 5'h10, PAT);
    recv("echo full", 8'h40, 5'h10, PAT);
    send(8'h00, 5'h11, PAT);
    recv("echo long", 8'hC0, 5'h00, '0);
    slow <= 1'b0;
    send(8'h01, 5'h00, '0);
    recv("version", 8'h41, 5'h10, '0);
    send(8'h02, 5'h10, UD);
    recv("user write", 8'h42, 5'h00, '0);
    chk("stored", {n_we, nv_out}, {32'h1, UD[127:0]});
    send(8'h03, 5'h00, '0);
    recv("user read", 8'h43, 5'h10, UD);
    send(8'h04, 5'h00, '0);
    recv("save", 8'h44, 5'h00, '0);
    chk("save strobe", n_save, 1);
    send(8'h06, 5'h00, '0);
    recv("clear", 8'h46, 5'h00, '0);
    chk("clear strobe", n_clr, 1);
    send(8'h05, 5'h03, 176'h631207);
    recv("bad restart", 8'hC5, 5'h00, '0);
    for (int m = 0; m < 3; m++) begin
      send(8'h05, 5'h03, r5[m]);
      recv("restart", 8'h45, 5'h00, '0);
      repeat (3) @(posedge clk);
      chk("restart quiet", rdy, 1'b0);
      wait_rdy();
    end
    chk("pulses", {n_hr, n_pw, n_load}, {32'd20, 32'd10, 32'd4});
    close_out();
  end
endmodule : pkt_cmd_core_bench
`default_nettype wire
